// ### inc/rmc_pkg.sv
package rmc_pkg;

	// Clock and timing
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned CE_MIN_US = 10;
	localparam int unsigned CE_MIN_CYCLES = (CE_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CE_CNT_W = $clog2(CE_MIN_CYCLES + 1);
	localparam int unsigned SLOT_US = 128;
	localparam int unsigned SLOT_CYCLES = (SLOT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned POR_CYCLES = 16;
	localparam int unsigned POR_CNT_W = 5;

	// Register byte offsets
	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_AIR_RATE = 8'h04;
	localparam logic [7:0] OFS_CHANNEL = 8'h08;
	localparam logic [7:0] OFS_STATE = 8'h0c;
	localparam logic [7:0] OFS_EVENTS = 8'h10;
	localparam logic [7:0] OFS_SIG_CTRL = 8'h14;
	localparam logic [7:0] OFS_SIG_HIST = 8'h18;

	// Config register fields
	localparam int unsigned CFG_PWR_BIT = 0;
	localparam int unsigned CFG_ROLE_BIT = 1;
	localparam int unsigned CFG_AUTO_ACK_BIT = 2;
	localparam int unsigned CFG_MASK_LSB = 4;
	localparam logic [7:0] CFG_RESET = 8'h00;

	// Air rate codes and channel
	localparam logic [1:0] RATE_1M = 2'h0;
	localparam logic [1:0] RATE_2M = 2'h1;
	localparam logic [1:0] RATE_250K = 2'h2;
	localparam logic [1:0] RATE_RESET = 2'h0;
	localparam logic [6:0] CHAN_RESET = 7'h02;

	// Signal-strength control and history
	localparam int unsigned SIG_EN_BIT = 4;
	localparam int unsigned HIST_THR1_LSB = 16;
	localparam int unsigned HIST_THR2_LSB = 24;
	localparam logic [7:0] THR1_RESET = 8'h40;
	localparam logic [7:0] THR2_RESET = 8'h80;

	// Event flag positions
	localparam int unsigned EVT_TX_SENT = 0;
	localparam int unsigned EVT_RX_STORED = 1;

	typedef enum logic [2:0] {
		RMC_ST_POR,
		RMC_ST_PDOWN,
		RMC_ST_STANDBY,
		RMC_ST_TX,
		RMC_ST_TX_IDLE,
		RMC_ST_ACK_WAIT,
		RMC_ST_RX,
		RMC_ST_ACK_SEND
	} rmc_state_e;

	// Events from packet engine, same clock
	typedef struct packed {
		logic tx_waiting;
		logic tx_done;
		logic rx_valid;
		logic ack_ok;
		logic ack_timeout;
	} rmc_modem_evt_s;

	// Controls to radio and packet engine
	typedef struct packed {
		logic osc_on;
		logic radio_on;
		logic tx_mode;
		logic rx_listen;
		logic tx_start;
		logic rx_store;
	} rmc_radio_ctl_s;

endpackage

// ### logic/rmc_sig_recorder.sv
`timescale 1ns/100ps
module rmc_sig_recorder #(
	parameter int unsigned SLOT_CYCLES = rmc_pkg::SLOT_CYCLES,
	parameter logic [15:0] DEVICE_ID = 16'h3c5a // Arbitrary value
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic enable,
	input wire logic link_clk,
	input wire logic [7:0] level_in,
	input wire logic [1:0][7:0] thresholds,
	output logic [15:0] history,
	output logic [1:0] flags
);
	localparam int unsigned SLOT_W = $clog2(SLOT_CYCLES + 1);

	logic lk_meta, lk_sync, lk_prev;
	logic [7:0] lvl_meta, lvl_sync, sample_reg;
	logic [SLOT_W-1:0] slot_cnt;
	logic slot_end;

	// Two-stage sync of link clock and level; level is stable around the edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lk_meta <= 1'b0;
			lk_sync <= 1'b0;
			lk_prev <= 1'b0;
			lvl_meta <= 8'h00;
			lvl_sync <= 8'h00;
		end else begin
			lk_meta <= link_clk;
			lk_sync <= lk_meta;
			lk_prev <= lk_sync;
			lvl_meta <= level_in;
			lvl_sync <= lvl_meta;
		end
	end

	// Capture level on each rising link edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sample_reg <= 8'h00;
		end else if (lk_sync && !lk_prev) begin
			sample_reg <= lvl_sync;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slot_cnt <= '0;
		end else if (!enable || slot_end) begin
			slot_cnt <= '0;
		end else begin
			slot_cnt <= slot_cnt + 1'b1;
		end
	end
	assign slot_end = enable && (slot_cnt == SLOT_W'(SLOT_CYCLES - 1));

	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_rec
			logic flag_reg, acc_reg;
			logic [7:0] hist_reg;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					flag_reg <= 1'b0;
				end else begin
					flag_reg <= enable && (sample_reg > thresholds[i]);
				end
			end
			// Sticky over the slot so short peaks still count
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					acc_reg <= 1'b0;
				end else if (slot_end || !enable) begin
					acc_reg <= 1'b0;
				end else if (flag_reg) begin
					acc_reg <= 1'b1;
				end
			end
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					hist_reg <= DEVICE_ID[i*8 +: 8];
				end else if (slot_end) begin
					hist_reg <= {hist_reg[6:0], acc_reg | flag_reg};
				end
			end
			assign history[i*8 +: 8] = hist_reg;
			assign flags[i] = flag_reg;
		end
	endgenerate

endmodule

// ### logic/rmc_top.sv
// The APB register port was left to the implementer.
`timescale 1ns/100ps
module rmc_top #(
	parameter int unsigned SLOT_CYCLES = rmc_pkg::SLOT_CYCLES,
	parameter logic [15:0] DEVICE_ID = 16'h3c5a // Arbitrary value
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ce_pin,
	input wire logic link_clk,
	input wire logic [7:0] level_in,
	input wire rmc_pkg::rmc_modem_evt_s modem_evt,
	output rmc_pkg::rmc_radio_ctl_s radio_ctl,
	output logic [1:0] air_rate,
	output logic [6:0] channel,
	output logic irq_n
);

	logic [7:0] cfg_reg;
	logic [1:0] rate_reg;
	logic [6:0] chan_reg;
	logic [1:0] evt_reg;
	logic sig_en_reg;
	logic [7:0] thr1_reg, thr2_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;
	logic irq_n_reg;
	logic ce_meta, ce_sync;
	logic [rmc_pkg::CE_CNT_W-1:0] ce_cnt;
	logic ce_qual;
	logic [rmc_pkg::POR_CNT_W-1:0] por_cnt;
	rmc_pkg::rmc_state_e state_reg, state_next;
	rmc_pkg::rmc_radio_ctl_s ctl_reg;
	logic [15:0] history;
	logic [1:0] sig_flags;
	logic pwr, role_rx, auto_ack;
	logic wr_en, rd_setup;
	logic [1:0] evt_set;
	logic tx_pkt_end;

	// Address decode for the error answer; the read mux decodes on its own
	function automatic logic addr_mapped(input logic [7:0] a);
		addr_mapped = (a == rmc_pkg::OFS_CONFIG) || (a == rmc_pkg::OFS_AIR_RATE) ||
			(a == rmc_pkg::OFS_CHANNEL) || (a == rmc_pkg::OFS_STATE) ||
			(a == rmc_pkg::OFS_EVENTS) || (a == rmc_pkg::OFS_SIG_CTRL) ||
			(a == rmc_pkg::OFS_SIG_HIST);
	endfunction

	assign pwr = cfg_reg[rmc_pkg::CFG_PWR_BIT];
	assign role_rx = cfg_reg[rmc_pkg::CFG_ROLE_BIT];
	assign auto_ack = cfg_reg[rmc_pkg::CFG_AUTO_ACK_BIT];

	// Zero-wait slave; read data is prepared in the setup cycle
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite;
	assign rd_setup = psel && !penable;
	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg;

	// Config, rate and channel registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg <= rmc_pkg::CFG_RESET;
			rate_reg <= rmc_pkg::RATE_RESET;
			chan_reg <= rmc_pkg::CHAN_RESET;
		end else if (wr_en) begin
			if (paddr == rmc_pkg::OFS_CONFIG) begin
				cfg_reg <= pwdata[7:0];
			end
			if (paddr == rmc_pkg::OFS_AIR_RATE) begin
				rate_reg <= pwdata[1:0];
			end
			if (paddr == rmc_pkg::OFS_CHANNEL) begin
				chan_reg <= pwdata[6:0];
			end
		end
	end

	// thresholds live in the history word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sig_en_reg <= 1'b0;
			thr1_reg <= rmc_pkg::THR1_RESET;
			thr2_reg <= rmc_pkg::THR2_RESET;
		end else if (wr_en) begin
			if (paddr == rmc_pkg::OFS_SIG_CTRL) begin
				sig_en_reg <= pwdata[rmc_pkg::SIG_EN_BIT];
			end
			if (paddr == rmc_pkg::OFS_SIG_HIST) begin
				thr1_reg <= pwdata[rmc_pkg::HIST_THR1_LSB +: 8];
				thr2_reg <= pwdata[rmc_pkg::HIST_THR2_LSB +: 8];
			end
		end
	end

	// Read mux, latched in setup so prdata comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else if (rd_setup) begin
			pslverr_reg <= !addr_mapped(paddr);
			prdata_reg <= 32'h0000_0000;
			unique case (paddr)
				rmc_pkg::OFS_CONFIG: prdata_reg <= {24'h00_0000, cfg_reg};
				rmc_pkg::OFS_AIR_RATE: prdata_reg <= {30'h0000_0000, rate_reg};
				rmc_pkg::OFS_CHANNEL: prdata_reg <= {25'h000_0000, chan_reg};
				rmc_pkg::OFS_STATE: prdata_reg <= {29'h0000_0000, state_reg};
				rmc_pkg::OFS_EVENTS: prdata_reg <= {30'h0000_0000, evt_reg};
				rmc_pkg::OFS_SIG_CTRL: prdata_reg <= {27'h000_0000, sig_en_reg, 2'h0, sig_flags};
				// thresholds and histories in one word
				rmc_pkg::OFS_SIG_HIST: prdata_reg <= {thr2_reg, thr1_reg, history};
				default: prdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	// Chip enable pin synchroniser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ce_meta <= 1'b0;
			ce_sync <= 1'b0;
		end else begin
			ce_meta <= ce_pin;
			ce_sync <= ce_meta;
		end
	end

	// qualify chip enable high for the minimum pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ce_cnt <= '0;
		end else if (!ce_sync) begin
			ce_cnt <= '0;
		end else if (!ce_qual) begin
			ce_cnt <= ce_cnt + 1'b1;
		end
	end
	assign ce_qual = (ce_cnt == rmc_pkg::CE_CNT_W'(rmc_pkg::CE_MIN_CYCLES));

	// Power-on reset sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			por_cnt <= '0;
		end else if (state_reg == rmc_pkg::RMC_ST_POR) begin
			por_cnt <= por_cnt + 1'b1;
		end
	end

	assign tx_pkt_end = (state_reg == rmc_pkg::RMC_ST_TX) && modem_evt.tx_done;

	// Operating state selection
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			rmc_pkg::RMC_ST_POR: begin
				if (por_cnt == rmc_pkg::POR_CNT_W'(rmc_pkg::POR_CYCLES - 1)) begin
					state_next = rmc_pkg::RMC_ST_PDOWN;
				end
			end
			rmc_pkg::RMC_ST_PDOWN: begin
				if (pwr) begin
					state_next = rmc_pkg::RMC_ST_STANDBY;
				end
			end
			rmc_pkg::RMC_ST_STANDBY: begin
				// role bit picks receive or transmit path
				if (role_rx && ce_sync) begin
					state_next = rmc_pkg::RMC_ST_RX;
				// transmit needs role, power, qualified chip enable and payload
				end else if (!role_rx && ce_qual && modem_evt.tx_waiting) begin
					state_next = rmc_pkg::RMC_ST_TX;
				end
			end
			rmc_pkg::RMC_ST_TX: begin
				if (modem_evt.tx_done) begin
					if (auto_ack) begin
						state_next = rmc_pkg::RMC_ST_ACK_WAIT;
					end else if (ce_sync && modem_evt.tx_waiting) begin
						state_next = rmc_pkg::RMC_ST_TX;
					end else if (ce_sync) begin
						state_next = rmc_pkg::RMC_ST_TX_IDLE;
					end else begin
						state_next = rmc_pkg::RMC_ST_STANDBY;
					end
				end
			end
			rmc_pkg::RMC_ST_ACK_WAIT: begin
				if (modem_evt.ack_timeout) begin
					state_next = rmc_pkg::RMC_ST_TX;
				end else if (modem_evt.ack_ok) begin
					if (ce_sync && modem_evt.tx_waiting) begin
						state_next = rmc_pkg::RMC_ST_TX;
					end else if (ce_sync) begin
						state_next = rmc_pkg::RMC_ST_TX_IDLE;
					end else begin
						state_next = rmc_pkg::RMC_ST_STANDBY;
					end
				end
			end
			rmc_pkg::RMC_ST_TX_IDLE: begin
				if (!ce_sync) begin
					state_next = rmc_pkg::RMC_ST_STANDBY;
				end else if (modem_evt.tx_waiting) begin
					state_next = rmc_pkg::RMC_ST_TX;
				end
			end
			rmc_pkg::RMC_ST_RX: begin
				if (modem_evt.rx_valid && auto_ack) begin
					state_next = rmc_pkg::RMC_ST_ACK_SEND;
				end else if (!ce_sync) begin
					state_next = rmc_pkg::RMC_ST_STANDBY;
				end
			end
			rmc_pkg::RMC_ST_ACK_SEND: begin
				if (modem_evt.tx_done) begin
					state_next = ce_sync ? rmc_pkg::RMC_ST_RX : rmc_pkg::RMC_ST_STANDBY;
				end
			end
		endcase
		// power bit low overrides every state except power-on reset
		if (!pwr && state_reg != rmc_pkg::RMC_ST_POR) begin
			state_next = rmc_pkg::RMC_ST_PDOWN;
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= rmc_pkg::RMC_ST_POR;
		end else begin
			state_reg <= state_next;
		end
	end

	// Radio controls registered from the next state; rx_store from the current state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_reg <= '0;
		end else begin
			ctl_reg.osc_on <= (state_next != rmc_pkg::RMC_ST_POR) && (state_next != rmc_pkg::RMC_ST_PDOWN);
			// no radio in standby or idle transmit
			ctl_reg.radio_on <= (state_next == rmc_pkg::RMC_ST_TX) || (state_next == rmc_pkg::RMC_ST_RX) ||
				(state_next == rmc_pkg::RMC_ST_ACK_WAIT) || (state_next == rmc_pkg::RMC_ST_ACK_SEND);
			ctl_reg.tx_mode <= (state_next == rmc_pkg::RMC_ST_TX) || (state_next == rmc_pkg::RMC_ST_ACK_SEND);
			ctl_reg.rx_listen <= (state_next == rmc_pkg::RMC_ST_RX) || (state_next == rmc_pkg::RMC_ST_ACK_WAIT);
			// one start per packet, also on back-to-back sends
			ctl_reg.tx_start <= ((state_next == rmc_pkg::RMC_ST_TX) && (state_reg != state_next || tx_pkt_end)) ||
				((state_next == rmc_pkg::RMC_ST_ACK_SEND) && (state_reg != state_next));
			ctl_reg.rx_store <= (state_reg == rmc_pkg::RMC_ST_RX) && modem_evt.rx_valid;
		end
	end
	assign radio_ctl = ctl_reg;

	// Rate and channel drive the synthesiser directly
	assign air_rate = rate_reg;
	assign channel = chan_reg;

	// Sticky event flags, hardware set beats software clear
	assign evt_set[rmc_pkg::EVT_TX_SENT] = (tx_pkt_end && !auto_ack) ||
		((state_reg == rmc_pkg::RMC_ST_ACK_WAIT) && modem_evt.ack_ok && !modem_evt.ack_timeout);
	assign evt_set[rmc_pkg::EVT_RX_STORED] = (state_reg == rmc_pkg::RMC_ST_RX) && modem_evt.rx_valid;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_reg <= 2'h0;
		end else if (wr_en && paddr == rmc_pkg::OFS_EVENTS) begin
			evt_reg <= (evt_reg & ~pwdata[1:0]) | evt_set;
		end else begin
			evt_reg <= evt_reg | evt_set;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_n_reg <= 1'b1;
		end else begin
			irq_n_reg <= !(|(evt_reg & cfg_reg[rmc_pkg::CFG_MASK_LSB +: 2]));
		end
	end
	assign irq_n = irq_n_reg;

	rmc_sig_recorder #(
		.SLOT_CYCLES(SLOT_CYCLES),
		.DEVICE_ID(DEVICE_ID)
	) u_rec (
		.pclk(pclk),
		.presetn(presetn),
		.enable(sig_en_reg && pwr),
		.link_clk(link_clk),
		.level_in(level_in),
		.thresholds({thr2_reg, thr1_reg}),
		.history(history),
		.flags(sig_flags)
	);

endmodule

// ### testbench/rmc_pkt_model.sv
`timescale 1ns/100ps
module rmc_pkt_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire rmc_pkg::rmc_radio_ctl_s radio_ctl,
	input wire logic load,
	input wire logic ack_on,
	input wire logic [1:0] ack_fails,
	input wire logic rx_go,
	output rmc_pkg::rmc_modem_evt_s modem_evt
);
	logic [2:0] cnt_reg, air_reg, ackw_reg, used;
	logic [1:0] fail_reg;
	logic done_reg, ok_reg, to_reg, rxv_reg;
	// Payload leaves the queue once sent, or once acknowledged
	assign used = {2'h0, done_reg && !ack_on} + {2'h0, ok_reg};
	assign modem_evt = '{tx_waiting: cnt_reg > used, tx_done: done_reg, rx_valid: rxv_reg,
		ack_ok: ok_reg, ack_timeout: to_reg};
	// Airtime, acknowledge wait and reception; packets arrive only while listening
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= 3'h0;
			air_reg <= 3'h0;
			ackw_reg <= 3'h0;
			fail_reg <= 2'h0;
			done_reg <= 1'b0;
			ok_reg <= 1'b0;
			to_reg <= 1'b0;
			rxv_reg <= 1'b0;
		end else begin
			air_reg <= radio_ctl.tx_start ? 3'h4 : air_reg - {2'h0, air_reg != 3'h0};
			done_reg <= air_reg == 3'h1;
			ackw_reg <= (done_reg && ack_on) ? 3'h5 : ackw_reg - {2'h0, ackw_reg != 3'h0};
			to_reg <= ackw_reg == 3'h1 && fail_reg != 2'h0;
			ok_reg <= ackw_reg == 3'h1 && fail_reg == 2'h0;
			fail_reg <= load ? ack_fails : fail_reg - {1'b0, to_reg};
			cnt_reg <= cnt_reg + {2'h0, load} - (cnt_reg != 3'h0 ? used : 3'h0);
			rxv_reg <= rx_go && radio_ctl.rx_listen;
		end
	end
endmodule

// ### testbench/rmc_top_chk.sv
`timescale 1ns/100ps
module rmc_top_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic ce_pin,
	input wire rmc_pkg::rmc_modem_evt_s modem_evt,
	input wire rmc_pkg::rmc_radio_ctl_s radio_ctl,
	input wire logic [1:0] air_rate,
	input wire logic [6:0] channel
);
	logic [7:0] cfg_reg;
	logic wr_acc;
	// Write lands only at the access edge
	assign wr_acc = psel && penable && pwrite;
	// Shadow of config: bit 0 power, bit 1 role, bit 2 auto acknowledge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg <= rmc_pkg::CFG_RESET;
		end else if (wr_acc && paddr == rmc_pkg::OFS_CONFIG) begin
			cfg_reg <= pwdata[7:0];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Three cycles of slack cover the registered state change
	a_pwr_off_dark: assert property ((!cfg_reg[0])[*3] |-> !radio_ctl.osc_on && !radio_ctl.radio_on)
		else $error("radio active while powered down");
	a_tx_needs_pwr: assert property (radio_ctl.tx_start |-> cfg_reg[0] && (!cfg_reg[1] || cfg_reg[2]))
		else $error("packet start without power or role");
	a_tx_one_pulse: assert property (radio_ctl.tx_start |=> !radio_ctl.tx_start)
		else $error("packet start longer than one cycle");
	a_rx_listens: assert property ((cfg_reg[1:0] == 2'h3 && ce_pin && !radio_ctl.tx_mode)[*8] |->
		radio_ctl.rx_listen) else $error("receiver deaf with chip enable high");
	a_rx_stores: assert property (modem_evt.rx_valid && radio_ctl.rx_listen && cfg_reg[1:0] == 2'h3 |->
		##[1:3] radio_ctl.rx_store) else $error("valid packet not stored");
	a_ack_reply: assert property (modem_evt.rx_valid && radio_ctl.rx_listen && cfg_reg[2:0] == 3'h7 |->
		##[1:3] radio_ctl.tx_start) else $error("no acknowledge sent");
	a_ack_listen: assert property (modem_evt.tx_done && radio_ctl.tx_mode && cfg_reg[2:0] == 3'h5 |->
		##[1:3] radio_ctl.rx_listen) else $error("no listen after transmit");
	a_ack_retry: assert property (modem_evt.ack_timeout && radio_ctl.rx_listen && cfg_reg[2:0] == 3'h5 |->
		##[1:3] radio_ctl.tx_start) else $error("no retransmit after timeout");
	a_rate_follow: assert property (wr_acc && paddr == rmc_pkg::OFS_AIR_RATE |=>
		air_rate == $past(pwdata[1:0])) else $error("air rate not updated");
	a_chan_follow: assert property (wr_acc && paddr == rmc_pkg::OFS_CHANNEL |=>
		channel == $past(pwdata[6:0])) else $error("channel not updated");
	c_tx: cover property (radio_ctl.tx_start);
	c_rx_store: cover property (radio_ctl.rx_store);
	c_retry: cover property (modem_evt.ack_timeout && radio_ctl.rx_listen);
	c_tx_idle: cover property (radio_ctl.osc_on && !radio_ctl.radio_on && ce_pin);
endmodule
bind rmc_top rmc_top_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .ce_pin(ce_pin), .modem_evt(modem_evt),
	.radio_ctl(radio_ctl), .air_rate(air_rate), .channel(channel));

// ### testbench/test_rmc_top.sv
`timescale 1ns/100ps
module test_rmc_top;
	localparam int unsigned SLOT = 16;
	// Arbitrary identifier value
	localparam logic [15:0] DEV_ID = 16'h5a17;
	localparam int unsigned CE_N = rmc_pkg::CE_MIN_CYCLES;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ce_pin = 1'b0, link_clk = 1'b0;
	logic load = 1'b0, ack_on = 1'b0, rx_go = 1'b0, pready, pslverr, err, irq_n;
	logic [7:0] paddr = 8'h00, level_in = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic [1:0] ack_fails = 2'h0, air_rate;
	logic [6:0] channel;
	rmc_pkg::rmc_modem_evt_s modem_evt;
	rmc_pkg::rmc_radio_ctl_s radio_ctl;
	int mismatches = 0, cmp_count = 0, n_tx = 0, n_rx = 0;
	logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14};
	logic [31:0] rv [5] = '{32'h0, 32'h0, 32'h2, 32'h0, 32'h0};
	logic [1:0] rt [3] = '{rmc_pkg::RATE_250K, rmc_pkg::RATE_1M, rmc_pkg::RATE_2M};
	logic [7:0] lv [4] = '{8'h10, 8'h40, 8'h60, 8'h90};
	logic [15:0] hv [4] = '{16'h0000, 16'h0000, 16'h00ff, 16'hffff};
	logic [1:0] fl [4] = '{2'h0, 2'h0, 2'h1, 2'h3};
	// Clocks; link clock runs free at 80 ns, offset from pclk
	always #5 pclk = ~pclk;
	initial #3 forever #40 link_clk = ~link_clk;
	rmc_top #(.SLOT_CYCLES(SLOT), .DEVICE_ID(DEV_ID)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ce_pin(ce_pin), .link_clk(link_clk), .level_in(level_in), .modem_evt(modem_evt),
		.radio_ctl(radio_ctl), .air_rate(air_rate), .channel(channel), .irq_n(irq_n));
	rmc_pkt_model u_pkt (.pclk(pclk), .presetn(presetn), .radio_ctl(radio_ctl), .load(load),
		.ack_on(ack_on), .ack_fails(ack_fails), .rx_go(rx_go), .modem_evt(modem_evt));
	// Count packet starts and stored payloads
	always @(posedge pclk) begin
		n_tx <= n_tx + int'(radio_ctl.tx_start === 1'b1);
		n_rx <= n_rx + int'(radio_ctl.rx_store === 1'b1);
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report();
		if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// One transfer; answer taken at the edge where pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the answer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0);
		check(what, rdat, exp);
	endtask
	// Poll the state word, bounded
	task automatic wait_state(input logic [2:0] s);
		int n;
		n = 0;
		do begin
			apb(1'b0, rmc_pkg::OFS_STATE, 32'h0);
			n++;
		end while (rdat[2:0] !== s && n < 500);
		check("state", rdat, {29'h0, s});
	endtask
	task automatic wait_tx(input int exp);
		int n;
		n = 0;
		while (n_tx < exp && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		check("packet starts", n_tx, exp);
	endtask
	task automatic ce_for(input int n);
		@(posedge pclk);
		ce_pin <= 1'b1;
		repeat (n) @(posedge pclk);
		ce_pin <= 1'b0;
	endtask
	task automatic pulse_load();
		@(posedge pclk);
		load <= 1'b1;
		@(posedge pclk);
		load <= 1'b0;
	endtask
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		wait_state(3'h1);
		rd(rmc_pkg::OFS_SIG_HIST, {rmc_pkg::THR2_RESET, rmc_pkg::THR1_RESET, DEV_ID}, "id");
		foreach (ra[i]) rd(ra[i], rv[i], "reset value");
		rd(8'h40, 32'h0, "unmapped");
		check("unmapped error", err, 32'h1);
		// Every rate code reaches the port
		foreach (rt[i]) begin
			apb(1'b1, rmc_pkg::OFS_AIR_RATE, {30'h0, rt[i]});
			@(posedge pclk);
			check("air rate", air_rate, rt[i]);
		end
		apb(1'b1, rmc_pkg::OFS_CHANNEL, 32'h54);
		@(posedge pclk);
		check("channel", channel, 32'h54);
		// 2 MHz clear of the default channel at the fast rate
		apb(1'b1, rmc_pkg::OFS_CHANNEL, 32'h4);
		apb(1'b1, rmc_pkg::OFS_STATE, 32'h7);
		rd(rmc_pkg::OFS_STATE, 32'h1, "read-only state");
		apb(1'b1, rmc_pkg::OFS_CONFIG, 32'h1);
		wait_state(3'h2);
		check("oscillator", radio_ctl.osc_on, 32'h1);
		pulse_load();
		pulse_load();
		ce_for(CE_N / 2);
		repeat (1100) @(posedge pclk);
		check("short enable", n_tx, 32'h0);
		// Pulse must end before the first packet does, or it counts as held
		ce_for(CE_N + 2);
		wait_tx(1);
		wait_state(3'h2);
		check("single packet", n_tx, 32'h1);
		// Held enable drains two queued packets back to back, then waits
		pulse_load();
		@(posedge pclk);
		ce_pin <= 1'b1;
		wait_tx(3);
		wait_state(3'h4);
		check("radio idle", radio_ctl.radio_on, 32'h0);
		pulse_load();
		wait_tx(4);
		@(posedge pclk);
		ce_pin <= 1'b0;
		wait_state(3'h2);
		ack_fails <= 2'h1;
		pulse_load();
		apb(1'b1, rmc_pkg::OFS_CONFIG, 32'h0);
		ce_for(CE_N + 20);
		check("no packet when off", n_tx, 32'h4);
		wait_state(3'h1);
		// One lost acknowledge, then success
		ack_on <= 1'b1;
		apb(1'b1, rmc_pkg::OFS_CONFIG, 32'h5);
		ce_for(CE_N + 20);
		wait_tx(6);
		wait_state(3'h2);
		// Masked event pulls the interrupt low until software clears it
		rd(rmc_pkg::OFS_EVENTS, 32'h1, "events");
		apb(1'b1, rmc_pkg::OFS_CONFIG, 32'h15);
		repeat (2) @(posedge pclk);
		check("irq active", irq_n, 32'h0);
		apb(1'b1, rmc_pkg::OFS_EVENTS, 32'h1);
		repeat (2) @(posedge pclk);
		check("irq cleared", irq_n, 32'h1);
		ack_on <= 1'b0;
		apb(1'b1, rmc_pkg::OFS_CONFIG, 32'h7);
		@(posedge pclk);
		ce_pin <= 1'b1;
		wait_state(3'h6);
		@(posedge pclk);
		rx_go <= 1'b1;
		@(posedge pclk);
		rx_go <= 1'b0;
		wait_tx(7);
		check("stored", n_rx, 32'h1);
		wait_state(3'h6);
		@(posedge pclk);
		ce_pin <= 1'b0;
		wait_state(3'h2);
		// Recorder: low, boundary, medium and high levels
		apb(1'b1, rmc_pkg::OFS_CONFIG, 32'h1);
		apb(1'b1, rmc_pkg::OFS_SIG_CTRL, 32'h10);
		apb(1'b1, rmc_pkg::OFS_SIG_HIST, 32'h80400000);
		foreach (lv[i]) begin
			@(negedge link_clk);
			@(posedge pclk);
			level_in <= lv[i];
			repeat (SLOT * 10) @(posedge pclk);
			rd(rmc_pkg::OFS_SIG_HIST, {16'h8040, hv[i]}, "history");
			rd(rmc_pkg::OFS_SIG_CTRL, {27'h0, 1'b1, 2'h0, fl[i]}, "flags");
		end
		final_report();
	end
	// Hang guard, well beyond the expected run
	initial begin
		repeat (60000) @(posedge pclk);
		mismatches++;
		final_report();
	end
endmodule
